//--- core/gpap_pkg.sv
// Package of constants for the eight-pin port with analog gate.
package gpap_pkg;
  localparam int unsigned WIDTH          = 8;
  localparam int unsigned ADDR_W         = 3;
  localparam logic [2:0]  OFS_LATCH      = 3'h0;
  localparam logic [2:0]  OFS_DIR        = 3'h1;
  localparam logic [2:0]  OFS_PULLUP     = 3'h2;
  localparam logic [2:0]  OFS_AGATE      = 3'h3;
  localparam logic [2:0]  OFS_CTRL       = 3'h4;
  localparam logic [2:0]  OFS_PINSTAT    = 3'h5;
  localparam int unsigned CTRL_FLOAT_BIT = 0;
  localparam int unsigned CTRL_CMPD_BIT  = 1;
  localparam logic [7:0]  RST_LATCH      = 8'h00;
  localparam logic [7:0]  RST_DIR        = 8'h00;
  localparam logic [7:0]  RST_PULLUP     = 8'h00;
  localparam logic [7:0]  RST_AGATE      = 8'h00;
  localparam logic        RST_FLOAT      = 1'h0;
  localparam logic        RST_CMPD       = 1'h1;
  localparam int unsigned PIN_TIMER_A    = 5;
  localparam int unsigned PIN_TIMER_B    = 6;
  localparam int unsigned PIN_LIN_RX     = 4;
  localparam int unsigned PIN_CMP_PLUS   = 0;
  localparam int unsigned PIN_CMP_MINUS  = 1;
endpackage

//--- core/gpap_sync.sv
// Two-flop synchroniser for a vector of pin levels.
`timescale 1ns/1ps
module gpap_sync #(
  parameter int unsigned W = 8
) (
  // Clock and reset.
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic         clk_en,
  // Data.
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta <= '0;
      q    <= '0;
    end else if (clk_en) begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule

//--- core/gpap_pin.sv
// Output, pull-up and input gating of one port pin.
`timescale 1ns/1ps
module gpap_pin (
  // Configuration.
  input  wire logic latch,
  input  wire logic dir,
  input  wire logic pull_en,
  input  wire logic agate,
  input  wire logic periph_oe,
  input  wire logic periph_out,
  input  wire logic float_now,
  input  wire logic irq_en,
  // Pin and results.
  input  wire logic pin_level,
  output logic      pad_out,
  output logic      pad_oe,
  output logic      pad_pullup,
  output logic      din,
  output logic      irq_level
);
  logic blocked;

  // Standby float blocks the pin input unless its interrupt is enabled.
  assign blocked    = float_now && !irq_en;
  // Peripheral output wins over the port latch.
  assign pad_out    = periph_oe ? periph_out : latch;
  // Standby float releases every pad, interrupt pins included.
  assign pad_oe     = (periph_oe || dir) && !float_now;
  // Pull-up drops while the pin drives low or floats.
  assign pad_pullup = pull_en && !float_now && !(pad_oe && !pad_out);
  // Digital input only when the gate is open and not blocked.
  assign din        = agate && !blocked && pin_level;
  // Interrupt path always sees the pin unless it is blocked.
  assign irq_level  = !blocked && pin_level;
endmodule

//--- core/gpap_port.sv
// Eight-pin port with output latch, direction, pull-up and analog gate.
//
// Notes on behaviour
// - Direction bit one drives the latch value onto the pin.
// - Latch writes always store; pin sees them only when output.
// - Output pins read back the latch value.
// - Input pins read the pin; read-modify-write reads the latch.
// - Peripheral output enable drives the pin; reads show the pin.
// - Gate bit one enables digital input; zero selects analog.
// - Reset clears direction and gate bits to zero.
// - Float bit set in stop or watch floats and blocks pins.
// - Float bit clear in stop or watch holds pin states.
// - Pin level reaches the external interrupt circuit unless the pin floats with its interrupt disabled.
// - Pull-up bit connects pull-up except while driving low.
// - Comparator disable bit zero enables comparator inputs on pins 0, 1.
// - Pins 5, 6 carry timer outputs; pin 4 feeds rx and clock.
// - Peripheral input pins read back the pin level.
// - Read-modify-write reads return the last written latch.
`timescale 1ns/1ps
module gpap_port #(
  parameter int unsigned W = gpap_pkg::WIDTH
) (
  // Clock, reset and enable.
  input  wire logic                        clk,
  input  wire logic                        arst_n,
  input  wire logic                        clk_en,
  // Register port.
  input  wire logic [gpap_pkg::ADDR_W-1:0] addr,
  input  wire logic [7:0]                  wdata,
  input  wire logic                        wr,
  input  wire logic                        rd,
  input  wire logic                        rd_rmw,
  output logic      [7:0]                  rdata,
  // Standby and interrupt control.
  input  wire logic                        standby_stop_watch,
  input  wire logic [W-1:0]                ext_irq_enable,
  output logic      [W-1:0]                ext_irq_level,
  // Timer and serial sharing.
  input  wire logic                        timer0_output_a,
  input  wire logic                        timer0_output_a_oe,
  input  wire logic                        timer0_output_b,
  input  wire logic                        timer0_output_b_oe,
  input  wire logic [W-1:0]                other_periph_out,
  input  wire logic [W-1:0]                other_periph_oe,
  output logic                             lin_serial_rx,
  output logic                             timer0_ext_clock_in,
  // Analog and comparator.
  output logic      [W-1:0]                analog_select,
  output logic                             comparator_plus_en,
  output logic                             comparator_minus_en,
  // Pads.
  input  wire logic [W-1:0]                pad_in,
  output logic      [W-1:0]                pad_out,
  output logic      [W-1:0]                pad_oe,
  output logic      [W-1:0]                pad_pullup
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers.
  logic [W-1:0] port_output_latch;
  logic [W-1:0] port_direction;
  logic [W-1:0] port_pullup_enable;
  logic [W-1:0] analog_input_gate;
  logic         standby_pin_float_bit;
  logic         comparator_input_disable;
  logic         float_held;
  logic         hold_active;
  logic [W-1:0] pin_sync;
  logic [W-1:0] periph_oe;
  logic [W-1:0] periph_out;
  logic [W-1:0] live_out;
  logic [W-1:0] live_oe;
  logic [W-1:0] live_pu;
  logic [W-1:0] held_out;
  logic [W-1:0] held_oe;
  logic [W-1:0] held_pu;
  logic [W-1:0] din;
  logic [W-1:0] pin_view;
  logic [7:0]   next_rdata;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      port_output_latch <= gpap_pkg::RST_LATCH;
    end else if (clk_en && wr && addr == gpap_pkg::OFS_LATCH) begin
      port_output_latch <= wdata[W-1:0];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      port_direction     <= gpap_pkg::RST_DIR;
      port_pullup_enable <= gpap_pkg::RST_PULLUP;
      analog_input_gate  <= gpap_pkg::RST_AGATE;
    end else if (clk_en && wr) begin
      if (addr == gpap_pkg::OFS_DIR) begin
        port_direction <= wdata[W-1:0];
      end
      if (addr == gpap_pkg::OFS_PULLUP) begin
        port_pullup_enable <= wdata[W-1:0];
      end
      if (addr == gpap_pkg::OFS_AGATE) begin
        analog_input_gate <= wdata[W-1:0];
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      standby_pin_float_bit    <= gpap_pkg::RST_FLOAT;
      comparator_input_disable <= gpap_pkg::RST_CMPD;
    end else if (clk_en && wr && addr == gpap_pkg::OFS_CTRL) begin
      standby_pin_float_bit    <= wdata[gpap_pkg::CTRL_FLOAT_BIT];
      comparator_input_disable <= wdata[gpap_pkg::CTRL_CMPD_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Standby entry captures the float choice and the pad state.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hold_active <= 1'h0;
      float_held  <= 1'h0;
    end else if (clk_en) begin
      if (standby_stop_watch && !hold_active) begin
        hold_active <= 1'h1;
        float_held  <= standby_pin_float_bit;
      end else if (!standby_stop_watch) begin
        hold_active <= 1'h0;
        float_held  <= 1'h0;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      held_out <= '0;
      held_oe  <= '0;
      held_pu  <= '0;
    end else if (clk_en && standby_stop_watch && !hold_active) begin
      held_out <= live_out;
      held_oe  <= live_oe;
      held_pu  <= live_pu;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin input synchroniser.
  gpap_sync #(
    .W (W)
  ) u_sync (
    .clk    (clk),
    .arst_n (arst_n),
    .clk_en (clk_en),
    .d      (pad_in),
    .q      (pin_sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Peripheral sharing: timer outputs on pins 5 and 6.
  always_comb begin
    periph_oe  = other_periph_oe;
    periph_out = other_periph_out;
    periph_oe[gpap_pkg::PIN_TIMER_A]  = timer0_output_a_oe;
    periph_out[gpap_pkg::PIN_TIMER_A] = timer0_output_a;
    periph_oe[gpap_pkg::PIN_TIMER_B]  = timer0_output_b_oe;
    periph_out[gpap_pkg::PIN_TIMER_B] = timer0_output_b;
  end

  for (genvar i = 0; i < W; i++) begin : g_pin
    gpap_pin u_pin (
      .latch      (port_output_latch[i]),
      .dir        (port_direction[i]),
      .pull_en    (port_pullup_enable[i]),
      .agate      (analog_input_gate[i]),
      .periph_oe  (periph_oe[i]),
      .periph_out (periph_out[i]),
      .float_now  (float_held),
      .irq_en     (ext_irq_enable[i]),
      .pin_level  (pin_sync[i]),
      .pad_out    (live_out[i]),
      .pad_oe     (live_oe[i]),
      .pad_pullup (live_pu[i]),
      .din        (din[i]),
      .irq_level  (ext_irq_level[i])
    );
  end

  // Hold mode freezes pads; float mode is already applied per pin.
  assign pad_out    = (hold_active && !float_held) ? held_out : live_out;
  assign pad_oe     = (hold_active && !float_held) ? held_oe  : live_oe;
  assign pad_pullup = (hold_active && !float_held) ? held_pu  : live_pu;

  assign lin_serial_rx       = din[gpap_pkg::PIN_LIN_RX];
  assign timer0_ext_clock_in = din[gpap_pkg::PIN_LIN_RX];
  assign analog_select       = ~analog_input_gate;
  assign comparator_plus_en  = !comparator_input_disable;
  assign comparator_minus_en = !comparator_input_disable;

  ////////////////////////////////////////////////////////////////////////////
  // Read path: outputs show the latch, inputs and peripherals the pin.
  always_comb begin
    for (int j = 0; j < W; j++) begin
      pin_view[j] = (port_direction[j] && !periph_oe[j]) ? port_output_latch[j]
                                                        : din[j];
    end
  end

  always_comb begin
    next_rdata = 8'h00;
    unique case (addr)
      gpap_pkg::OFS_LATCH:   next_rdata[W-1:0] = rd_rmw ? port_output_latch
                                                        : pin_view;
      gpap_pkg::OFS_DIR:     next_rdata[W-1:0] = port_direction;
      gpap_pkg::OFS_PULLUP:  next_rdata[W-1:0] = port_pullup_enable;
      gpap_pkg::OFS_AGATE:   next_rdata[W-1:0] = analog_input_gate;
      gpap_pkg::OFS_CTRL: begin
        next_rdata[gpap_pkg::CTRL_FLOAT_BIT] = standby_pin_float_bit;
        next_rdata[gpap_pkg::CTRL_CMPD_BIT]  = comparator_input_disable;
      end
      gpap_pkg::OFS_PINSTAT: next_rdata[W-1:0] = pin_sync;
      default:               next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= 8'h00;
    end else if (clk_en) begin
      rdata <= rd ? next_rdata : 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.
  sequence s_latch_write;
    wr && addr == gpap_pkg::OFS_LATCH && clk_en;
  endsequence

  property p_drive_latch;
    @(posedge clk) disable iff (!arst_n)
      (port_direction[0] && !periph_oe[0] && !hold_active)
      |-> pad_oe[0] && pad_out[0] == port_output_latch[0];
  endproperty
  a_drive_latch: assert property (p_drive_latch) else $error("output pin not driving latch");

  property p_latch_store;
    @(posedge clk) disable iff (!arst_n)
      s_latch_write |=> port_output_latch == $past(wdata[W-1:0]);
  endproperty
  a_latch_store: assert property (p_latch_store) else $error("latch write lost");

  property p_out_read;
    @(posedge clk) disable iff (!arst_n)
      (clk_en && rd && !rd_rmw && addr == gpap_pkg::OFS_LATCH && port_direction == 8'hff
       && periph_oe == 8'h00) |=> rdata == $past(port_output_latch);
  endproperty
  a_out_read: assert property (p_out_read) else $error("output read not latch");

  property p_rmw_read;
    @(posedge clk) disable iff (!arst_n)
      (clk_en && rd && rd_rmw && addr == gpap_pkg::OFS_LATCH)
      |=> rdata == $past(port_output_latch);
  endproperty
  a_rmw_read: assert property (p_rmw_read) else $error("rmw read not latch");

  property p_in_read;
    @(posedge clk) disable iff (!arst_n)
      (clk_en && rd && !rd_rmw && addr == gpap_pkg::OFS_LATCH && port_direction == 8'h00
       && analog_input_gate == 8'hff && !float_held) |=> rdata == $past(pin_sync);
  endproperty
  a_in_read: assert property (p_in_read) else $error("input read not pin");

  property p_gate;
    @(posedge clk) disable iff (!arst_n)
      !analog_input_gate[0] |-> !din[0] && analog_select[0];
  endproperty
  a_gate: assert property (p_gate) else $error("closed gate passes input");

  property p_float;
    @(posedge clk) disable iff (!arst_n)
      (float_held && !ext_irq_enable[0]) |-> !pad_oe[0] && !ext_irq_level[0];
  endproperty
  a_float: assert property (p_float) else $error("floated pin still active");

  property p_hold;
    @(posedge clk) disable iff (!arst_n)
      (hold_active && !float_held && $stable(hold_active)) |-> $stable(pad_out) && $stable(pad_oe);
  endproperty
  a_hold: assert property (p_hold) else $error("held pins changed");

  property p_pullup_low;
    @(posedge clk) disable iff (!arst_n)
      (pad_oe[0] && !pad_out[0]) |-> !pad_pullup[0];
  endproperty
  a_pullup_low: assert property (p_pullup_low) else $error("pull-up on while low");

  property p_cmp;
    @(posedge clk) disable iff (!arst_n)
      comparator_plus_en == !comparator_input_disable;
  endproperty
  a_cmp: assert property (p_cmp) else $error("comparator enable wrong");

  sequence s_dir_write;
    wr && addr == gpap_pkg::OFS_DIR && clk_en;
  endsequence

  sequence s_stby_entry;
    standby_stop_watch && !hold_active && clk_en;
  endsequence

  property p_dir_store;
    @(posedge clk) disable iff (!arst_n)
      s_dir_write |=> port_direction == $past(wdata[W-1:0]);
  endproperty
  a_dir_store: assert property (p_dir_store) else $error("direction write lost");

  property p_entry;
    @(posedge clk) disable iff (!arst_n)
      s_stby_entry |=> hold_active && float_held == $past(standby_pin_float_bit);
  endproperty
  a_entry: assert property (p_entry) else $error("standby entry not captured");

  property p_float_all;
    @(posedge clk) disable iff (!arst_n)
      float_held |-> pad_oe == '0 && pad_pullup == '0;
  endproperty
  a_float_all: assert property (p_float_all) else $error("floated pin still driven");

  property p_irq_route;
    @(posedge clk) disable iff (!arst_n)
      !float_held |-> ext_irq_level == pin_sync;
  endproperty
  a_irq_route: assert property (p_irq_route) else $error("pin level not at interrupt");

  property p_timer_pin;
    @(posedge clk) disable iff (!arst_n)
      (timer0_output_a_oe && !hold_active)
      |-> pad_oe[gpap_pkg::PIN_TIMER_A] && pad_out[gpap_pkg::PIN_TIMER_A] == timer0_output_a;
  endproperty
  a_timer_pin: assert property (p_timer_pin) else $error("timer output not on its pin");

  property p_rx_route;
    @(posedge clk) disable iff (!arst_n)
      (analog_input_gate[gpap_pkg::PIN_LIN_RX] && !float_held)
      |-> lin_serial_rx == pin_sync[gpap_pkg::PIN_LIN_RX] && timer0_ext_clock_in == lin_serial_rx;
  endproperty
  a_rx_route: assert property (p_rx_route) else $error("rx pin not routed");

endmodule

//--- testbench/gpap_board.sv
// Board model that resolves each pad from the port, an external driver and the pull-up.
`timescale 1ns/1ps
module gpap_board (
  // Clock.
  input  wire logic       clk,
  // Port side.
  input  wire logic [7:0] pad_out,
  input  wire logic [7:0] pad_oe,
  input  wire logic [7:0] pad_pullup,
  // External driver.
  input  wire logic [7:0] ext_en,
  input  wire logic [7:0] ext_val,
  // Resolved levels.
  output logic      [7:0] pad_in
);
  logic [7:0] last = 8'h00;

  always_ff @(posedge clk) begin
    last <= pad_in;
  end

  // A pad that nobody drives and nothing pulls keeps changing, so a stale value never passes.
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pad_oe[i]) begin
        pad_in[i] = pad_out[i];
      end else if (ext_en[i]) begin
        pad_in[i] = ext_val[i];
      end else if (pad_pullup[i]) begin
        pad_in[i] = 1'b1;
      end else begin
        pad_in[i] = ~last[i];
      end
    end
  end
endmodule

//--- testbench/eight_bit_port_with_analog_gate_test.sv
// Self-checking bench for the eight-pin port with analog gate.
`timescale 1ns/1ps
module eight_bit_port_with_analog_gate_test;
  logic       clk     = 1'b0;
  logic       arst_n  = 1'b0;
  logic       clk_en  = 1'b1;
  logic [2:0] addr    = 3'h0;
  logic [7:0] wdata   = 8'h00;
  logic       wr      = 1'b0;
  logic       rd      = 1'b0;
  logic       rd_rmw  = 1'b0;
  logic       stby    = 1'b0;
  logic       ta      = 1'b0;
  logic       ta_oe   = 1'b0;
  logic       tb      = 1'b0;
  logic       tb_oe   = 1'b0;
  logic [7:0] irq_en  = 8'h00;
  logic [7:0] op_out  = 8'h00;
  logic [7:0] op_oe   = 8'h00;
  logic [7:0] ext_en  = 8'h00;
  logic [7:0] ext_val = 8'h00;
  logic [7:0] rdata, irq_lvl, asel, pad_in, pad_out, pad_oe, pad_pu, r;
  logic       lin_rx, ec_in, cmp_p, cmp_m;
  int         n_fail   = 0;
  int         n_checks = 0;

  always #2.5 clk = ~clk;

  gpap_port DUT (.clk(clk), .arst_n(arst_n), .clk_en(clk_en), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rd_rmw(rd_rmw), .rdata(rdata), .standby_stop_watch(stby),
    .ext_irq_enable(irq_en), .ext_irq_level(irq_lvl), .timer0_output_a(ta),
    .timer0_output_a_oe(ta_oe), .timer0_output_b(tb), .timer0_output_b_oe(tb_oe),
    .other_periph_out(op_out), .other_periph_oe(op_oe), .lin_serial_rx(lin_rx),
    .timer0_ext_clock_in(ec_in), .analog_select(asel), .comparator_plus_en(cmp_p),
    .comparator_minus_en(cmp_m), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
    .pad_pullup(pad_pu));

  gpap_board board (.clk(clk), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup(pad_pu),
    .ext_en(ext_en), .ext_val(ext_val), .pad_in(pad_in));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bus_wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  task automatic bus_rd(input logic [2:0] a, input logic rmw, output logic [7:0] d);
    @(posedge clk);
    addr   <= a;
    rd     <= 1'b1;
    rd_rmw <= rmw;
    @(posedge clk);
    rd     <= 1'b0;
    rd_rmw <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic wait_edges(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    #1 chk(pad_oe, 8'h00);
    chk(asel, 8'hff);
    chk({6'h00, cmp_p, cmp_m}, 8'h00);
    bus_rd(gpap_pkg::OFS_DIR, 1'b0, r);
    chk(r, 8'h00);
    bus_rd(gpap_pkg::OFS_AGATE, 1'b0, r);
    chk(r, 8'h00);
    bus_rd(gpap_pkg::OFS_PULLUP, 1'b0, r);
    chk(r, 8'h00);
    bus_rd(gpap_pkg::OFS_CTRL, 1'b0, r);
    chk(r & 8'h03, 8'h02);
  endtask

  task automatic t_output;
    bus_wr(gpap_pkg::OFS_LATCH, 8'h3c);
    #1 chk(pad_oe, 8'h00);
    bus_rd(gpap_pkg::OFS_LATCH, 1'b1, r);
    chk(r, 8'h3c);
    bus_wr(gpap_pkg::OFS_DIR, 8'hff);
    #1 chk(pad_oe, 8'hff);
    chk(pad_out, 8'h3c);
    bus_wr(gpap_pkg::OFS_LATCH, 8'ha5);
    bus_rd(gpap_pkg::OFS_LATCH, 1'b0, r);
    chk(r, 8'ha5);
    bus_wr(gpap_pkg::OFS_DIR, 8'h81);
    #1 chk(pad_oe, 8'h81);
  endtask

  task automatic t_input;
    bus_wr(gpap_pkg::OFS_DIR, 8'h00);
    bus_wr(gpap_pkg::OFS_AGATE, 8'hff);
    @(posedge clk);
    ext_en  <= 8'hff;
    ext_val <= 8'h5a;
    wait_edges(3);
    bus_rd(gpap_pkg::OFS_LATCH, 1'b0, r);
    chk(r, 8'h5a);
    chk(irq_lvl, 8'h5a);
    chk({6'h00, lin_rx, ec_in}, 8'h03);
    bus_wr(gpap_pkg::OFS_AGATE, 8'h00);
    #1 chk(asel, 8'hff);
    chk({6'h00, lin_rx, ec_in}, 8'h00);
    bus_rd(gpap_pkg::OFS_LATCH, 1'b0, r);
    chk(r, 8'h00);
  endtask

  task automatic t_periph;
    bus_wr(gpap_pkg::OFS_LATCH, 8'h00);
    bus_wr(gpap_pkg::OFS_AGATE, 8'hff);
    @(posedge clk);
    ext_en <= 8'h00;
    ta     <= 1'b1;
    ta_oe  <= 1'b1;
    tb_oe  <= 1'b1;
    op_out <= 8'h04;
    op_oe  <= 8'h04;
    wait_edges(3);
    chk(pad_oe & 8'h64, 8'h64);
    chk(pad_out & 8'h64, 8'h24);
    bus_rd(gpap_pkg::OFS_LATCH, 1'b0, r);
    chk(r & 8'h64, 8'h24);
    bus_rd(gpap_pkg::OFS_LATCH, 1'b1, r);
    chk(r, 8'h00);
    @(posedge clk);
    ta_oe <= 1'b0;
    tb_oe <= 1'b0;
    op_oe <= 8'h00;
  endtask

  task automatic t_pullup;
    bus_wr(gpap_pkg::OFS_LATCH, 8'h0f);
    bus_wr(gpap_pkg::OFS_DIR, 8'hff);
    bus_wr(gpap_pkg::OFS_PULLUP, 8'hff);
    #1 chk(pad_pu, 8'h0f);
    bus_wr(gpap_pkg::OFS_DIR, 8'h00);
    wait_edges(3);
    chk(pad_pu, 8'hff);
    bus_rd(gpap_pkg::OFS_LATCH, 1'b0, r);
    chk(r, 8'hff);
  endtask

  task automatic t_standby;
    bus_wr(gpap_pkg::OFS_DIR, 8'hff);
    bus_wr(gpap_pkg::OFS_CTRL, 8'h03);
    ext_en  <= 8'hff;
    ext_val <= 8'hff;
    irq_en  <= 8'h01;
    stby    <= 1'b1;
    wait_edges(4);
    chk(pad_oe, 8'h00);
    chk(pad_pu, 8'h00);
    chk(irq_lvl, 8'h01);
    @(posedge clk);
    stby <= 1'b0;
    bus_wr(gpap_pkg::OFS_CTRL, 8'h00);
    #1 chk({6'h00, cmp_p, cmp_m}, 8'h03);
    @(posedge clk);
    stby <= 1'b1;
    wait_edges(4);
    bus_wr(gpap_pkg::OFS_LATCH, 8'hf0);
    #1 chk(pad_oe, 8'hff);
    chk(pad_out, 8'h0f);
    chk(irq_lvl, 8'h0f);
    @(posedge clk);
    stby   <= 1'b0;
    irq_en <= 8'h00;
    wait_edges(2);
    chk(pad_out, 8'hf0);
  endtask

  task automatic t_unmapped;
    bus_wr(3'h6, 8'hff);
    bus_rd(3'h6, 1'b0, r);
    chk(r, 8'h00);
    bus_rd(3'h7, 1'b0, r);
    chk(r, 8'h00);
    @(posedge clk);
    clk_en <= 1'b0;
    bus_wr(gpap_pkg::OFS_PULLUP, 8'h00);
    @(posedge clk);
    clk_en <= 1'b1;
    bus_rd(gpap_pkg::OFS_PULLUP, 1'b0, r);
    chk(r, 8'hff);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    t_reset();
    t_output();
    t_input();
    t_periph();
    t_pullup();
    t_standby();
    t_unmapped();
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    t_reset();
    end_of_test();
  end

  initial begin
    repeat (5000) @(posedge clk);
    n_fail++;
    $display("wrong value at %0t: run did not finish", $time);
    end_of_test();
  end
endmodule
